//--- cmpdc_pkg.sv
/*
  Constants, register map and carrier types for the comparator digital control block.
  Assumes a 20 MHz system clock and an 8-bit register view on a 32-bit classic Wishbone bus.
*/
package cmpdc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SETTLE_NS = 10000;
  localparam int unsigned SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_W = $clog2(SETTLE_CYC + 1);

  localparam int unsigned ADR_W = 10;
  localparam logic [7:0] IDX_PORT_A = 8'h05;
  localparam logic [7:0] IDX_PORT_C = 8'h07;
  localparam logic [7:0] IDX_IRQ_CTRL = 8'h0b;
  localparam logic [7:0] IDX_PFLAG = 8'h0c;
  localparam logic [7:0] IDX_CMAIN = 8'h19;
  localparam logic [7:0] IDX_CLINK = 8'h1a;
  localparam logic [7:0] IDX_DIR_A = 8'h85;
  localparam logic [7:0] IDX_DIR_C = 8'h87;
  localparam logic [7:0] IDX_PENABLE = 8'h8c;
  localparam logic [7:0] IDX_REFCTL = 8'h99;

  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned INV_LSB = 4;
  localparam int unsigned RES_LSB = 6;
  localparam int unsigned SYNC_BIT = 0;
  localparam int unsigned GSS_BIT = 1;
  localparam int unsigned FLAG_LSB = 3;
  localparam int unsigned PERIPH_EN_BIT = 6;
  localparam int unsigned GLOBAL_EN_BIT = 7;
  localparam int unsigned REF_EN_BIT = 7;
  localparam int unsigned REF_RANGE_BIT = 5;
  localparam int unsigned CM1_PIN_BIT = 2;
  localparam int unsigned CM2_PIN_BIT = 4;

  localparam logic [5:0] CMAIN_RST = 6'h00;
  localparam logic [1:0] CLINK_RST = 2'h2;
  localparam logic [7:0] REF_RST = 8'h00;
  localparam logic [7:0] REF_WMASK = 8'haf;
  localparam logic [5:0] DIR_RST = 6'h3f;

  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [2:0] MODE_OFF = 3'h7;
  localparam logic [7:0] MODE_PINOUT_MASK = 8'h28;
  localparam logic [5:0] ANALOG_MASK_A = 6'h03;
  localparam logic [5:0] ANALOG_MASK_C = 6'h03;

  typedef struct packed {
    logic cmp1_out;
    logic cmp1_oe;
    logic cmp2_out;
    logic cmp2_oe;
  } cmpdc_pins_t;

  typedef struct packed {
    logic enable;
    logic range;
    logic [3:0] level;
    logic [6:0] tap_96ths;
  } cmpdc_ref_t;

  typedef struct packed {
    logic [5:0] cmain;
    logic [1:0] link;
    logic [1:0] pflag;
    logic [1:0] pen;
    logic [1:0] irqc;
    logic [7:0] refc;
    logic [5:0] dir_a;
    logic [5:0] dir_c;
    logic [1:0] snap;
    logic [SETTLE_W-1:0] settle;
    logic ack;
    logic [7:0] rdat;
  } cmpdc_state_t;

  typedef struct packed {
    logic tick_prev;
    logic latched;
  } cmpdc_sync_t;
endpackage : cmpdc_pkg

//--- cmpdc_gate_sync.sv
/*
  Comparator 2 synchroniser and timer gate source select.
  Assumes timer and prescaler clocks arrive as levels synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module cmpdc_gate_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // controls
  input wire logic sync_en_i,
  input wire logic gss_i,
  input wire logic prescale_used_i,
  // sources
  input wire logic cmp2_i,
  input wire logic gate_pin_i,
  input wire logic timer_clk_i,
  input wire logic prescale_clk_i,
  // results
  output logic cmp2_gate_src_o,
  output logic gate_o
);
  import cmpdc_pkg::*;

  cmpdc_sync_t s_q;
  cmpdc_sync_t s_d;
  logic tick;
  logic fall;

  assign tick = prescale_used_i ? prescale_clk_i : timer_clk_i;
  assign fall = s_q.tick_prev & ~tick;

  always_comb begin
    s_d = s_q;
    s_d.tick_prev = tick;
    if (fall) begin
      s_d.latched = cmp2_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cmp2_gate_src_o = sync_en_i ? s_q.latched : cmp2_i;
  assign gate_o = gss_i ? gate_pin_i : cmp2_gate_src_o;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  gate_pin_sel_a: assert property (gss_i |-> gate_o == gate_pin_i)
    else $error("gate not taken from pin");
  gate_cmp_sel_a: assert property (!gss_i && !sync_en_i |-> gate_o == cmp2_i)
    else $error("unsynced comparator not on gate");
  latch_on_fall_a: assert property (fall |=> s_q.latched == $past(cmp2_i))
    else $error("latch missed falling edge");
  latch_hold_a: assert property (!fall |=> $stable(s_q.latched))
    else $error("latch moved without falling edge");
  prescale_src_a: assert property (
    prescale_used_i && $fell(prescale_clk_i) && !$past(prescale_used_i, 1) == 0
    |=> s_q.latched == $past(cmp2_i))
    else $error("prescaler edge not latching");
  sync_fall_c: cover property (sync_en_i && fall && cmp2_i);
endmodule : cmpdc_gate_sync
`default_nettype wire

//--- cmpdc_top.sv
/*
  Comparator digital control: mode, inversion, pin routing, change flags,
  interrupt request, reference selection and timer gate source.
  Assumes a classic Wishbone master, analog comparator cells and a timer outside.
*/
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module cmpdc_top #(
  parameter int unsigned SETTLE_CYCLES = cmpdc_pkg::SETTLE_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [cmpdc_pkg::ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // analog comparator cells
  input wire logic [1:0] raw_cmp_i,
  // port pins as inputs
  input wire logic [5:0] port_a_pins_i,
  input wire logic [5:0] port_c_pins_i,
  // timer side
  input wire logic gate_input_pin_i,
  input wire logic timer_clk_i,
  input wire logic prescale_clk_i,
  input wire logic prescale_used_i,
  output logic timer_gate_o,
  // comparator output pins
  output cmpdc_pkg::cmpdc_pins_t pins_o,
  // reference generator
  output cmpdc_pkg::cmpdc_ref_t ref_o,
  // status
  output logic [2:0] cmp_mode_field_o,
  output logic result_valid_o,
  output logic cmp_irq_req_o
);
  import cmpdc_pkg::*;

  cmpdc_state_t s_q;
  cmpdc_state_t s_d;

  localparam cmpdc_state_t RESET_STATE = '{
    cmain: CMAIN_RST,
    link: CLINK_RST,
    pflag: 2'h0,
    pen: 2'h0,
    irqc: 2'h0,
    refc: REF_RST,
    dir_a: DIR_RST,
    dir_c: DIR_RST,
    snap: 2'h0,
    settle: '0,
    ack: 1'b0,
    rdat: 8'h00
  };
  localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(SETTLE_CYCLES);

  logic [7:0] idx;
  logic req;
  logic acc;
  logic wr;
  logic [7:0] wdat;
  logic [2:0] mode;
  logic cmp_on;
  logic [1:0] result;
  logic [1:0] mismatch;
  logic [5:0] analog_a;
  logic [5:0] analog_c;
  logic [7:0] rd_mux;
  logic pin_mode;
  logic cmp2_gate_src;

  assign idx = adr_i[ADR_W-1:2];
  assign req = cyc_i & stb_i & ~s_q.ack;
  // request completes at the edge where ack is high
  assign acc = cyc_i & stb_i & s_q.ack;
  assign wr = acc & we_i & sel_i[0];
  assign wdat = dat_i[7:0];
  assign mode = s_q.cmain[MODE_LSB +: 3];

  // comparators powered only outside reset and off modes
  assign cmp_on = (mode != MODE_RESET) && (mode != MODE_OFF);
  assign result = cmp_on ? (raw_cmp_i ^ s_q.cmain[INV_LSB +: 2]) : 2'h0;
  // old snapshot is compared, so a change during an access still flags
  assign mismatch = result ^ s_q.snap;

  // pins used as comparator inputs read as zero
  assign analog_a = (mode == MODE_OFF) ? 6'h00 : ANALOG_MASK_A;
  assign analog_c = (mode == MODE_OFF) ? 6'h00 : ANALOG_MASK_C;

  always_comb begin
    rd_mux = 8'h00;
    unique case (idx)
      IDX_CMAIN: rd_mux = {result[1], result[0], s_q.cmain};
      IDX_CLINK: rd_mux = {6'h00, s_q.link};
      IDX_PFLAG: rd_mux = {3'h0, s_q.pflag, 3'h0};
      IDX_PENABLE: rd_mux = {3'h0, s_q.pen, 3'h0};
      IDX_IRQ_CTRL: rd_mux = {s_q.irqc, 6'h00};
      IDX_REFCTL: rd_mux = s_q.refc & REF_WMASK;
      IDX_DIR_A: rd_mux = {2'h0, s_q.dir_a};
      IDX_DIR_C: rd_mux = {2'h0, s_q.dir_c};
      IDX_PORT_A: rd_mux = {2'h0, port_a_pins_i & ~analog_a};
      IDX_PORT_C: rd_mux = {2'h0, port_c_pins_i & ~analog_c};
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.ack = req;
    if (req) begin
      s_d.rdat = rd_mux;
    end
    if (s_d.settle != '0) begin
      s_d.settle = s_q.settle - 1'b1;
    end
    if (wr) begin
      unique case (idx)
        IDX_CMAIN: begin
          // result bits 7:6 have no storage
          s_d.cmain = wdat[5:0];
          if (wdat[MODE_LSB +: 3] != mode) begin
            s_d.settle = SETTLE_LOAD;
          end
        end
        IDX_CLINK: s_d.link = wdat[1:0];
        IDX_PENABLE: s_d.pen = wdat[FLAG_LSB +: 2];
        IDX_IRQ_CTRL: s_d.irqc = wdat[PERIPH_EN_BIT +: 2];
        IDX_REFCTL: s_d.refc = wdat & REF_WMASK;
        IDX_DIR_A: s_d.dir_a = wdat[5:0];
        IDX_DIR_C: s_d.dir_c = wdat[5:0];
        default: s_d.rdat = s_d.rdat;
      endcase
    end
    // any access to the control register ends the mismatch
    if (acc && idx == IDX_CMAIN) begin
      s_d.snap = result;
    end
    for (int k = 0; k < 2; k++) begin
      if (mismatch[k] || (wr && idx == IDX_PFLAG && wdat[FLAG_LSB + k])) begin
        s_d.pflag[k] = 1'b1;
      end else if (wr && idx == IDX_PFLAG) begin
        s_d.pflag[k] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  assign ack_o = s_q.ack;
  assign dat_o = {24'h000000, s_q.rdat};
  assign cmp_mode_field_o = mode;
  assign result_valid_o = (s_q.settle == '0);

  assign cmp_irq_req_o = (|(s_q.pflag & s_q.pen)) & s_q.irqc[0] & s_q.irqc[1];

  // pin routing: mode chooses the multiplexer, direction bit gates the driver
  assign pin_mode = MODE_PINOUT_MASK[mode];
  assign pins_o.cmp1_out = result[0];
  assign pins_o.cmp2_out = result[1];
  assign pins_o.cmp1_oe = pin_mode & ~s_q.dir_a[CM1_PIN_BIT];
  assign pins_o.cmp2_oe = pin_mode & ~s_q.dir_c[CM2_PIN_BIT];

  // reference tap in 96ths of supply
  assign ref_o.enable = s_q.refc[REF_EN_BIT];
  assign ref_o.range = s_q.refc[REF_RANGE_BIT];
  assign ref_o.level = s_q.refc[3:0];
  assign ref_o.tap_96ths = ref_o.range ? 7'({ref_o.level, 2'b00})
                                       : 7'(7'd24 + 7'(ref_o.level) * 7'd3);

  cmpdc_gate_sync u_gate_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sync_en_i(s_q.link[SYNC_BIT]),
    .gss_i(s_q.link[GSS_BIT]),
    .prescale_used_i(prescale_used_i),
    .cmp2_i(result[1]),
    .gate_pin_i(gate_input_pin_i),
    .timer_clk_i(timer_clk_i),
    .prescale_clk_i(prescale_clk_i),
    .cmp2_gate_src_o(cmp2_gate_src),
    .gate_o(timer_gate_o)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_single_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  reset_values_a: assert property ($fell(rst_i) |-> mode == MODE_RESET && s_q.link == CLINK_RST)
    else $error("control registers not at reset values");
  settle_hold_a: assert property (
    wr && idx == IDX_CMAIN && wdat[2:0] != mode |=> !result_valid_o && s_q.settle == SETTLE_LOAD)
    else $error("result valid too soon after mode change");
  off_mode_a: assert property (mode == MODE_OFF |-> result == 2'h0)
    else $error("comparators active in off mode");
  flag_set_a: assert property (mismatch[0] |=> s_q.pflag[0])
    else $error("change did not set flag");
  flag_clear_a: assert property (
    wr && idx == IDX_PFLAG && wdat[4:3] == 2'h0 && mismatch == 2'h0 |=> s_q.pflag == 2'h0)
    else $error("flag not cleared by zero write");
  mismatch_end_a: assert property (acc && idx == IDX_CMAIN |=> s_q.snap == $past(result))
    else $error("access did not end mismatch");
  irq_gate_a: assert property (!s_q.irqc[1] || !s_q.irqc[0] |-> !cmp_irq_req_o)
    else $error("request without enables");
  link_zero_a: assert property (req && !we_i && idx == IDX_CLINK |=> dat_o[7:2] == 6'h00)
    else $error("unimplemented link bits read non zero");
  result_ro_a: assert property (wr && idx == IDX_CMAIN |=> s_q.cmain == $past(wdat[5:0]))
    else $error("control write stored wrongly");
  pin_oe_a: assert property (s_q.dir_a[CM1_PIN_BIT] |-> !pins_o.cmp1_oe)
    else $error("pin driven while direction is input");
  port_analog_a: assert property (
    req && !we_i && idx == IDX_PORT_A && mode != MODE_OFF |=> dat_o[1:0] == 2'h0)
    else $error("analog pin read non zero");
  invert_a: assert property (cmp_on |-> result == (raw_cmp_i ^ s_q.cmain[5:4]))
    else $error("inversion not applied");
  tap_low_a: assert property (ref_o.range |-> ref_o.tap_96ths == {1'b0, ref_o.level, 2'b00})
    else $error("low range tap wrong");

  mode_change_c: cover property (wr && idx == IDX_CMAIN && wdat[2:0] != mode);
  flag_irq_c: cover property (cmp_irq_req_o);
  sim_irq_c: cover property (wr && idx == IDX_PFLAG && wdat[3]);
  gate_cmp_c: cover property (!s_q.link[GSS_BIT] && s_q.link[SYNC_BIT] && cmp2_gate_src);
endmodule : cmpdc_top
`default_nettype wire

//--- cmpdc_partner.sv
/*
  Model of the analog comparator cells and the timer clock sources.
  Assumes the bench commands comparator levels on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module cmpdc_partner (
  // clock
  input wire logic clk_i,
  // commanded comparator levels
  input wire logic [1:0] cmp_cmd_i,
  // toward the block
  output logic [1:0] raw_cmp_o,
  output logic timer_clk_o,
  output logic prescale_clk_o
);
  logic [3:0] sh_q = 4'h0;
  logic [5:0] cnt_q = 6'h00;
  // comparator answers two cycles after its inputs move
  always @(posedge clk_i) begin
    sh_q <= {sh_q[1:0], cmp_cmd_i};
    cnt_q <= cnt_q + 6'h01;
  end
  assign raw_cmp_o = sh_q[3:2];
  // free running timer clock, prescaled copy at a quarter of its rate
  assign timer_clk_o = cnt_q[3];
  assign prescale_clk_o = cnt_q[5];
endmodule : cmpdc_partner
`default_nettype wire

//--- testbench.sv
/*
  Self-checking bench for the comparator digital control block.
  Assumes the partner model supplies comparator results and timer clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cmpdc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [9:0] adr_i = 10'h000;
  logic [3:0] sel_i = 4'h1;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [1:0] raw_cmp_i;
  logic [5:0] port_a_pins_i = 6'h00;
  logic [5:0] port_c_pins_i = 6'h00;
  logic gate_input_pin_i = 1'b0;
  logic timer_clk_i;
  logic prescale_clk_i;
  logic prescale_used_i = 1'b0;
  logic timer_gate_o;
  cmpdc_pins_t pins_o;
  cmpdc_ref_t ref_o;
  logic [2:0] cmp_mode_field_o;
  logic result_valid_o;
  logic cmp_irq_req_o;
  logic [1:0] cmd = 2'h0;
  logic [1:0] inv;
  logic [1:0] ex;
  logic [2:0] md;
  logic [7:0] v;
  int error_cnt = 0;
  int checks = 0;
  int seed = 32'hb12bdc10;
  logic [7:0] exp_q[$];

  always #25 clk_i = ~clk_i;

  cmpdc_top #(.SETTLE_CYCLES(4)) u_cmpdc_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .raw_cmp_i, .port_a_pins_i, .port_c_pins_i,
    .gate_input_pin_i, .timer_clk_i, .prescale_clk_i, .prescale_used_i, .timer_gate_o,
    .pins_o, .ref_o, .cmp_mode_field_o, .result_valid_o, .cmp_irq_req_o);
  cmpdc_partner u_cmpdc_partner (.clk_i, .cmp_cmd_i(cmd), .raw_cmp_o(raw_cmp_i),
    .timer_clk_o(timer_clk_i), .prescale_clk_o(prescale_clk_i));

  task automatic end_of_test;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk

  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      error_cnt++;
      end_of_test();
    end
  endtask : tmo

  task automatic settle;
    @(posedge clk_i);
    #1;
  endtask : settle

  // one classic single cycle; read expectations go to the monitor's queue
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                    input logic [7:0] e);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h0, d};
    if (!w)
      exp_q.push_back(e);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    tmo(n, 20);
  endtask : wb

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00, e);
  endtask : rd

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d, 8'h00);
  endtask : wr

  task automatic wait_valid;
    int n;
    n = 0;
    while (result_valid_o !== 1'b1 && n < 50) begin
      settle();
      n++;
    end
    tmo(n, 50);
  endtask : wait_valid

  task automatic wait_lvl(input int p, input logic l);
    int n;
    n = 0;
    while ((p ? prescale_clk_i : timer_clk_i) !== l && n < 100) begin
      settle();
      n++;
    end
    tmo(n, 100);
  endtask : wait_lvl

  task automatic defaults;
    rd(IDX_CMAIN, 8'h00);
    rd(IDX_CLINK, 8'h02);
    rd(IDX_REFCTL, 8'h00);
    rd(IDX_DIR_A, 8'h3f);
    rd(IDX_PFLAG, 8'h00);
    rd(8'h40, 8'h00);
    chk(cmp_mode_field_o, 32'h0);
    chk(timer_gate_o, gate_input_pin_i);
  endtask : defaults

  function automatic logic [1:0] res(input logic [2:0] m, input logic [1:0] i,
                                     input logic [1:0] r);
    return (m == MODE_RESET || m == MODE_OFF) ? 2'b00 : r ^ i;
  endfunction : res

  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0)
      chk(dat_o, {24'h0, exp_q.pop_front()});
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    defaults();
    wr(IDX_CLINK, 8'hff);
    rd(IDX_CLINK, 8'h03);
    wr(IDX_CLINK, 8'h00);
    wr(IDX_DIR_A, 8'h3b);
    wr(IDX_DIR_C, 8'h2f);
    wr(IDX_PENABLE, 8'h00);
    for (int m = 1; m <= 8; m++) begin
      @(posedge clk_i);
      md = 3'(m);
      inv = 2'($random(seed));
      cmd <= 2'($random(seed));
      port_a_pins_i <= 6'($random(seed));
      port_c_pins_i <= 6'($random(seed));
      wr(IDX_CMAIN, {2'b11, inv, 1'b0, md});
      settle();
      chk(result_valid_o, 1'b0);
      wait_valid();
      ex = res(md, inv, cmd);
      rd(IDX_CMAIN, {ex, inv, 1'b0, md});
      rd(IDX_PORT_A, {2'b0, port_a_pins_i & (md == MODE_OFF ? 6'h3f : 6'h3c)});
      rd(IDX_PORT_C, {2'b0, port_c_pins_i & (md == MODE_OFF ? 6'h3f : 6'h3c)});
      chk(pins_o, {ex[0], MODE_PINOUT_MASK[md], ex[1], MODE_PINOUT_MASK[md]});
      chk(timer_gate_o, ex[1]);
      chk(cmp_mode_field_o, md);
    end
    // change flags and interrupt request
    cmd <= 2'b00;
    wr(IDX_CMAIN, 8'h03);
    settle();
    chk(result_valid_o, 1'b0);
    wait_valid();
    rd(IDX_CMAIN, 8'h03);
    wr(IDX_PFLAG, 8'h00);
    wr(IDX_PENABLE, 8'h18);
    wr(IDX_IRQ_CTRL, 8'hc0);
    settle();
    chk(cmp_irq_req_o, 1'b0);
    @(posedge clk_i);
    cmd <= 2'b01;
    repeat (4) settle();
    chk(cmp_irq_req_o, 1'b1);
    rd(IDX_PFLAG, 8'h08);
    wr(IDX_PFLAG, 8'h00);
    rd(IDX_PFLAG, 8'h08);
    rd(IDX_CMAIN, 8'h43);
    wr(IDX_PFLAG, 8'h00);
    rd(IDX_PFLAG, 8'h00);
    wr(IDX_PFLAG, 8'h10);
    rd(IDX_PFLAG, 8'h10);
    settle();
    chk(cmp_irq_req_o, 1'b1);
    wr(IDX_IRQ_CTRL, 8'h40);
    rd(IDX_PFLAG, 8'h10);
    chk(cmp_irq_req_o, 1'b0);
    wr(IDX_DIR_A, 8'h3f);
    settle();
    chk(pins_o.cmp1_oe, 1'b0);
    // reference levels
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'hff : 8'($random(seed));
      wr(IDX_REFCTL, v);
      rd(IDX_REFCTL, v & REF_WMASK);
      chk(ref_o, {v[7], v[5], v[3:0], v[5] ? {1'b0, v[3:0], 2'b0} : 7'(24 + 3 * v[3:0])});
    end
    // gate from pin, then comparator 2 through the latch
    wr(IDX_CLINK, 8'h02);
    for (int j = 0; j < 2; j++) begin
      @(posedge clk_i);
      gate_input_pin_i <= j[0];
      settle();
      chk(timer_gate_o, j[0]);
    end
    wr(IDX_CLINK, 8'h01);
    for (int p = 0; p < 2; p++) begin
      @(posedge clk_i);
      prescale_used_i <= p[0];
      wait_lvl(p, 1'b0);
      wait_lvl(p, 1'b1);
      @(posedge clk_i);
      cmd <= p ? 2'b01 : 2'b11;
      repeat (p ? 20 : 4) settle();
      chk(timer_gate_o, p[0]);
      wait_lvl(p, 1'b0);
      repeat (2) settle();
      chk(timer_gate_o, !p[0]);
    end
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    defaults();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
